// >>> design/dci_pkg.sv
// shared constants and types for the ddr3 command and address interface
package dci_pkg;
	localparam int BANKS = 8;
	localparam int BA_W = 3;
	localparam int ROW_W = 13;
	localparam int COL_W = 10;
	localparam int DQ_W = 16;
	localparam int LANES = 2;
	localparam int PAGE_BYTES = (2 ** COL_W) * DQ_W / 8;
	localparam int MR_N = 4;
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam logic [3:0] BURST_FULL = 4'h8;
	localparam logic [3:0] BURST_CHOP = 4'h4;
	// termination enable bits inside the mode registers
	localparam int MR1_RTT0 = 2;
	localparam int MR1_RTT1 = 6;
	localparam int MR1_RTT2 = 9;
	localparam int MR2_RTTWR = 9;
	// controller register map, byte addresses
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_CMD = 5'h08;
	localparam logic [4:0] REG_WDATA = 5'h0c;
	localparam logic [4:0] REG_MASK = 5'h10;
	localparam logic [4:0] REG_RDATA = 5'h14;
	localparam logic [4:0] REG_STAT = 5'h18;
	localparam int CTRL_CKE = 0;
	localparam int CTRL_ODT = 1;
	localparam int CTRL_RSTN = 2;
	localparam logic [2:0] CTRL_RST = 3'h5;
	localparam int ADDR_BA_LSB = 13;
	localparam logic [3:0] PINS_IDLE = 4'hf;
	// {cs_n, ras_n, cas_n, we_n}; anything with cs_n high is deselect
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR = 4'h4,
		CMD_RD = 4'h5,
		CMD_ZQ = 4'h6,
		CMD_NOP = 4'h7,
		CMD_DES = 4'h8
	} dci_cmd_t;
	typedef enum logic [1:0] {
		PW_ON = 2'b00,
		PW_PPD = 2'b01,
		PW_APD = 2'b10,
		PW_SR = 2'b11
	} dci_pwr_t;
endpackage : dci_pkg

// >>> design/dci_if.sv
// pins between the memory controller and the memory device
`timescale 1ns/1ps
interface dci_if;
	import dci_pkg::*;
	logic ck;
	logic rst_n;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic odt;
	logic [BA_W-1:0] ba;
	logic [ROW_W-1:0] a;
	logic [LANES-1:0] dm;
	logic [DQ_W-1:0] dq_c;
	logic dq_c_oe_n;
	logic [DQ_W-1:0] dq_d;
	logic dq_d_oe_n;
	logic dqs_c;
	logic dqs_c_oe_n;
	logic dqs_d;
	logic dqs_d_oe_n;
	logic [DQ_W-1:0] dq;
	logic dqs;
	// wire level from the enables; an undriven bus reads zero
	assign dq = !dq_c_oe_n ? dq_c : (!dq_d_oe_n ? dq_d : '0);
	assign dqs = !dqs_c_oe_n ? dqs_c : (!dqs_d_oe_n ? dqs_d : 1'b0);
	modport ctl (
		output ck, rst_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dm,
		output dq_c, dq_c_oe_n, dqs_c, dqs_c_oe_n,
		input dq, dqs
	);
	modport dev (
		input ck, rst_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, a, dm,
		input dq, dqs,
		output dq_d, dq_d_oe_n, dqs_d, dqs_d_oe_n
	);
endinterface : dci_if

// >>> design/dci_ctl.sv
// memory controller end: avalon register slave driving the memory pins
`timescale 1ns/1ps
module dci_ctl (
	input wire logic CLK_I, // system clock, 50 MHz
	input wire logic SYS_RST_I, // synchronous reset, high
	input wire logic [4:0] AVS_ADDRESS_I, // byte address
	input wire logic AVS_READ_I, // read request
	input wire logic AVS_WRITE_I, // write request
	input wire logic [31:0] AVS_WRITEDATA_I, // write data
	output logic [31:0] AVS_READDATA_O, // read data
	output logic AVS_WAITREQUEST_O, // stall
	dci_if.ctl PIN // memory pins
);
	import dci_pkg::*;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD = 2'b01,
		ST_WR = 2'b10,
		ST_RD = 2'b11
	} dci_st_t;

	logic wait_r;
	logic [31:0] rdo_r;
	logic acc;
	logic cmd_go;
	logic rw;
	logic [2:0] ctrl_r;
	logic [15:0] addr_r;
	dci_cmd_t cmd_r;
	logic [DQ_W-1:0] wdata_r;
	logic [DQ_W-1:0] rdata_r;
	logic [7:0] mask_r;
	dci_st_t st_r;
	logic busy_r;
	logic [1:0] ph_r;
	logic [3:0] len_r;
	logic [3:0] beat_r;
	logic ck_r, cke_r, odt_r, rstn_r;
	logic cs_n_r, ras_n_r, cas_n_r, we_n_r;
	logic [BA_W-1:0] ba_r;
	logic [ROW_W-1:0] a_r;
	logic [LANES-1:0] dm_r;
	logic [DQ_W-1:0] dq_r;
	logic dq_oe_n_r, dqs_r, dqs_oe_n_r;
	logic [DQ_W:0] s1_r;
	logic [DQ_W:0] s2_r;
	logic dqs_q_r;

	assign acc = (AVS_READ_I | AVS_WRITE_I) & ~wait_r;
	assign cmd_go = acc & AVS_WRITE_I & (AVS_ADDRESS_I == REG_CMD);
	assign rw = busy_r & (cmd_r == CMD_RD | cmd_r == CMD_WR);

	// one wait cycle per access; command writes stall while busy
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			wait_r <= 1'b1;
			rdo_r <= 32'h0;
		end else begin
			wait_r <= ~((AVS_READ_I | AVS_WRITE_I) & wait_r &
				~(AVS_WRITE_I & (AVS_ADDRESS_I == REG_CMD) & busy_r));
			if (AVS_READ_I && wait_r) begin
				case (AVS_ADDRESS_I)
				REG_CTRL: rdo_r <= {29'h0, ctrl_r};
				REG_ADDR: rdo_r <= {16'h0, addr_r};
				REG_CMD: rdo_r <= {28'h0, cmd_r};
				REG_WDATA: rdo_r <= {16'h0, wdata_r};
				REG_MASK: rdo_r <= {24'h0, mask_r};
				REG_RDATA: rdo_r <= {16'h0, rdata_r};
				REG_STAT: rdo_r <= {27'h0, beat_r, busy_r};
				default: rdo_r <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			ctrl_r <= CTRL_RST;
			addr_r <= 16'h0;
			cmd_r <= CMD_NOP;
			wdata_r <= 16'h0;
			mask_r <= 8'h0;
		end else if (acc && AVS_WRITE_I) begin
			case (AVS_ADDRESS_I)
			REG_CTRL: ctrl_r <= AVS_WRITEDATA_I[2:0];
			REG_ADDR: addr_r <= AVS_WRITEDATA_I[15:0];
			REG_CMD: cmd_r <= dci_cmd_t'(AVS_WRITEDATA_I[3:0]);
			REG_WDATA: wdata_r <= AVS_WRITEDATA_I[15:0];
			REG_MASK: mask_r <= AVS_WRITEDATA_I[7:0];
			default: ;
			endcase
		end
	end

	// read data and strobe come from the pins, two flops first
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			s1_r <= '0;
			s2_r <= '0;
			dqs_q_r <= 1'b0;
		end else begin
			s1_r <= {PIN.dqs, PIN.dq};
			s2_r <= s1_r;
			dqs_q_r <= s2_r[DQ_W];
		end
	end

	// memory clock is CLK_I over four; pins change while ck is low
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			ph_r <= 2'h0;
			ck_r <= 1'b0;
			cke_r <= 1'b0;
			odt_r <= 1'b0;
			rstn_r <= 1'b0;
		end else begin
			ph_r <= ph_r + 2'h1;
			ck_r <= (ph_r == 2'h1) | (ph_r == 2'h2);
			cke_r <= ctrl_r[CTRL_CKE] | rw;
			odt_r <= ctrl_r[CTRL_ODT];
			rstn_r <= ctrl_r[CTRL_RSTN];
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			st_r <= ST_IDLE;
			busy_r <= 1'b0;
			{cs_n_r, ras_n_r, cas_n_r, we_n_r} <= PINS_IDLE;
			ba_r <= '0;
			a_r <= '0;
			len_r <= 4'h0;
			beat_r <= 4'h0;
			dm_r <= '0;
			dq_r <= '0;
			dq_oe_n_r <= 1'b1;
			dqs_r <= 1'b0;
			dqs_oe_n_r <= 1'b1;
			rdata_r <= '0;
		end else begin
			if (cmd_go) begin
				busy_r <= 1'b1;
			end
			case (st_r)
			ST_IDLE: if (busy_r && ph_r == 2'h3) begin
				{cs_n_r, ras_n_r, cas_n_r, we_n_r} <= cmd_r;
				ba_r <= addr_r[ADDR_BA_LSB +: BA_W];
				a_r <= addr_r[ROW_W-1:0];
				len_r <= addr_r[BC_BIT] ? BURST_FULL : BURST_CHOP;
				beat_r <= 4'h0;
				st_r <= ST_CMD;
			end
			ST_CMD: if (ph_r == 2'h3) begin
				{cs_n_r, ras_n_r, cas_n_r, we_n_r} <= PINS_IDLE;
				if (cmd_r == CMD_WR) begin
					st_r <= ST_WR;
				end else if (cmd_r == CMD_RD) begin
					st_r <= ST_RD;
				end else begin
					st_r <= ST_IDLE;
					busy_r <= 1'b0;
				end
			end
			ST_WR: if (ph_r[0]) begin
				if (beat_r == len_r) begin
					dq_oe_n_r <= 1'b1;
					dqs_oe_n_r <= 1'b1;
					st_r <= ST_IDLE;
					busy_r <= 1'b0;
				end else begin
					dq_r <= DQ_W'(wdata_r + DQ_W'(beat_r));
					dm_r <= {LANES{mask_r[beat_r[2:0]]}};
					dq_oe_n_r <= 1'b0;
					dqs_oe_n_r <= 1'b0;
				end
			end else if (!dq_oe_n_r) begin
				// strobe edge sits mid-beat, one cycle after the data
				dqs_r <= ~dqs_r;
				beat_r <= beat_r + 4'h1;
			end
			ST_RD: if (s2_r[DQ_W] ^ dqs_q_r) begin
				if (beat_r == 4'h0) begin
					rdata_r <= s2_r[DQ_W-1:0];
				end
				beat_r <= beat_r + 4'h1;
				if (beat_r == len_r - 4'h1) begin
					st_r <= ST_IDLE;
					busy_r <= 1'b0;
				end
			end
			default: st_r <= ST_IDLE;
			endcase
		end
	end

	assign AVS_READDATA_O = rdo_r;
	assign AVS_WAITREQUEST_O = wait_r;
	assign PIN.ck = ck_r;
	assign PIN.rst_n = rstn_r;
	assign PIN.cke = cke_r;
	assign PIN.cs_n = cs_n_r;
	assign PIN.ras_n = ras_n_r;
	assign PIN.cas_n = cas_n_r;
	assign PIN.we_n = we_n_r;
	assign PIN.odt = odt_r;
	assign PIN.ba = ba_r;
	assign PIN.a = a_r;
	assign PIN.dm = dm_r;
	assign PIN.dq_c = dq_r;
	assign PIN.dq_c_oe_n = dq_oe_n_r;
	assign PIN.dqs_c = dqs_r;
	assign PIN.dqs_c_oe_n = dqs_oe_n_r;
endmodule : dci_ctl

// >>> design/dci_dev.sv
// memory device end: command decode, banks, power states, odt and data
`timescale 1ns/1ps
// How it works
// - eight banks picked by three bank bits
// - row with activate, column with read/write
// - activate opens a 2KB page per bank
// - pins sampled at rising memory clock
// - chip select high masks every command
// - cs, ras, cas, we form the command
// - cke low: self-refresh with refresh and banks closed, else power-down by bank state
// - controller keeps cke high during accesses
// - self-refresh exit on cke, no clock needed
// - power-down keeps only clock, odt, cke, reset
// - self-refresh keeps only cke and reset
// - odt high terminates both byte lanes
// - odt ignored in self-refresh or when disabled
// - masked write beats are discarded
// - bank bits pick the mode register
// - address bits carry the mode opcode
// - a10: auto-precharge, or precharge all
// - a12 low chops the burst to four
// - reset pin resets device, data lost
module dci_dev #(
	parameter int MEM_ROW_W = 1, // row bits kept in the array
	parameter int MEM_COL_W = 3 // column bits kept in the array
) (
	input wire logic CLK_I, // system clock, 50 MHz
	input wire logic SYS_RST_I, // synchronous reset, high
	dci_if.dev PIN, // memory pins
	output logic [dci_pkg::BANKS-1:0] BANK_OPEN_O, // open row per bank
	output dci_pkg::dci_pwr_t PWR_O, // power state
	output logic [dci_pkg::LANES-1:0] TERM_O, // termination per lane
	output dci_pkg::dci_cmd_t CMD_O, // last command taken
	output logic CMD_STB_O // pulse: command taken
);
	import dci_pkg::*;
	localparam int HI_W = BA_W + MEM_ROW_W;
	localparam int AW = HI_W + MEM_COL_W;
	localparam int MEM_D = 2 ** AW;
	localparam int IN_W = 8 + BA_W + ROW_W + 1 + LANES + DQ_W;

	logic [IN_W-1:0] s1_r;
	logic [IN_W-1:0] s2_r;
	logic rst_n_s, ck_s, cke_s, odt_s;
	logic cs_n_s, ras_n_s, cas_n_s, we_n_s, dqs_s;
	logic [BA_W-1:0] ba_s;
	logic [ROW_W-1:0] a_s;
	logic [LANES-1:0] dm_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_q_r, dqs_q_r;
	logic rst, ck_rise, dqs_edge, go, rtt_en, wbeat;
	dci_cmd_t cmd;
	dci_pwr_t pwr_r;
	logic [BANKS-1:0] open_r;
	logic [ROW_W-1:0] row_r [BANKS];
	logic [ROW_W-1:0] mr_r [MR_N];
	logic [3:0] wr_left_r, wr_beat_r, rd_left_r, rd_beat_r;
	logic [HI_W-1:0] wr_hi_r, rd_hi_r, hi_now;
	logic [MEM_COL_W-1:0] wr_col_r, rd_col_r;
	logic rd_ph_r;
	logic [AW-1:0] waddr;
	logic [AW-1:0] raddr;
	logic [DQ_W-1:0] rword;
	logic [LANES-1:0] term_r;
	logic [DQ_W-1:0] dq_r;
	logic dq_oe_n_r, dqs_r, dqs_oe_n_r;
	dci_cmd_t cmd_r;
	logic stb_r;

	// every pin crosses two flops; the memory clock is only a level here
	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {PIN.rst_n, PIN.ck, PIN.cke, PIN.odt, PIN.cs_n,
				PIN.ras_n, PIN.cas_n, PIN.we_n, PIN.ba, PIN.a,
				PIN.dqs, PIN.dm, PIN.dq};
			s2_r <= s1_r;
		end
	end
	assign {rst_n_s, ck_s, cke_s, odt_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
		ba_s, a_s, dqs_s, dm_s, dq_s} = s2_r;

	// pin reset wipes state and contents alike
	assign rst = SYS_RST_I | ~rst_n_s;

	always_ff @(posedge CLK_I) begin
		if (SYS_RST_I) begin
			ck_q_r <= 1'b0;
			dqs_q_r <= 1'b0;
		end else begin
			ck_q_r <= ck_s;
			dqs_q_r <= dqs_s;
		end
	end
	assign ck_rise = ck_s & ~ck_q_r;
	assign dqs_edge = dqs_s ^ dqs_q_r;

	always_comb begin
		if (cs_n_s) begin
			cmd = CMD_DES;
		end else begin
			cmd = dci_cmd_t'({1'b0, ras_n_s, cas_n_s, we_n_s});
		end
	end

	// command buffers are off in every power-down state
	assign go = ck_rise & cke_s & (pwr_r == PW_ON) & (cmd != CMD_DES);
	assign hi_now = {ba_s, row_r[ba_s][MEM_ROW_W-1:0]};
	assign wbeat = (wr_left_r != 4'h0) & dqs_edge & (pwr_r == PW_ON);

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			pwr_r <= PW_ON;
		end else begin
			case (pwr_r)
			PW_ON: if (ck_rise && !cke_s) begin
				if (cmd == CMD_REF && open_r == '0) begin
					pwr_r <= PW_SR;
				end else if (open_r != '0) begin
					pwr_r <= PW_APD;
				end else begin
					pwr_r <= PW_PPD;
				end
			end
			PW_PPD, PW_APD: if (ck_rise && cke_s) begin
				pwr_r <= PW_ON;
			end
			// exit watches cke alone, the clock may be stopped
			PW_SR: if (cke_s) begin
				pwr_r <= PW_ON;
			end
			default: pwr_r <= PW_ON;
			endcase
		end
	end

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			open_r <= '0;
			for (int i = 0; i < BANKS; i++) begin
				row_r[i] <= '0;
			end
		end else if (go) begin
			for (int i = 0; i < BANKS; i++) begin
				case (cmd)
				CMD_ACT: if (ba_s == BA_W'(i)) begin
					open_r[i] <= 1'b1;
					row_r[i] <= a_s;
				end
				CMD_PRE: if (a_s[AP_BIT] || ba_s == BA_W'(i)) begin
					open_r[i] <= 1'b0;
				end
				// auto-precharge closes at once; no timing is modelled
				CMD_RD, CMD_WR: if (a_s[AP_BIT] && ba_s == BA_W'(i)) begin
					open_r[i] <= 1'b0;
				end
				default: ;
				endcase
			end
		end
	end

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			for (int i = 0; i < MR_N; i++) begin
				mr_r[i] <= '0;
			end
		end else if (go && cmd == CMD_MRS) begin
			mr_r[ba_s[1:0]] <= a_s;
		end
	end

	assign rtt_en = mr_r[1][MR1_RTT0] | mr_r[1][MR1_RTT1] |
		mr_r[1][MR1_RTT2] | (|mr_r[2][MR2_RTTWR +: 2]);

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			term_r <= '0;
		end else if (pwr_r == PW_SR) begin
			term_r <= '0;
		end else if (ck_rise) begin
			term_r <= {LANES{odt_s & rtt_en}};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			wr_left_r <= 4'h0;
			wr_beat_r <= 4'h0;
			wr_hi_r <= '0;
			wr_col_r <= '0;
		end else if (go && cmd == CMD_WR) begin
			wr_left_r <= a_s[BC_BIT] ? BURST_FULL : BURST_CHOP;
			wr_beat_r <= 4'h0;
			wr_hi_r <= hi_now;
			wr_col_r <= a_s[MEM_COL_W-1:0];
		end else if (wbeat) begin
			wr_left_r <= wr_left_r - 4'h1;
			wr_beat_r <= wr_beat_r + 4'h1;
		end
	end

	// sequential burst order, wrapping inside the kept column bits
	assign waddr = {wr_hi_r, MEM_COL_W'(wr_col_r + MEM_COL_W'(wr_beat_r))};
	assign raddr = {rd_hi_r, MEM_COL_W'(rd_col_r + MEM_COL_W'(rd_beat_r))};

	for (genvar g = 0; g < LANES; g++) begin : g_lane
		logic [7:0] mem_r [MEM_D];
		always_ff @(posedge CLK_I) begin
			if (rst) begin
				for (int j = 0; j < MEM_D; j++) begin
					mem_r[j] <= 8'h0;
				end
			end else if (wbeat && !dm_s[g]) begin
				mem_r[waddr] <= dq_s[8*g +: 8];
			end
		end
		assign rword[8*g +: 8] = mem_r[raddr];
	end

	// read beats: data one cycle, strobe edge the next
	always_ff @(posedge CLK_I) begin
		if (rst) begin
			rd_left_r <= 4'h0;
			rd_beat_r <= 4'h0;
			rd_hi_r <= '0;
			rd_col_r <= '0;
			rd_ph_r <= 1'b0;
			dq_r <= '0;
			dq_oe_n_r <= 1'b1;
			dqs_r <= 1'b0;
			dqs_oe_n_r <= 1'b1;
		end else if (go && cmd == CMD_RD) begin
			rd_left_r <= a_s[BC_BIT] ? BURST_FULL : BURST_CHOP;
			rd_beat_r <= 4'h0;
			rd_hi_r <= hi_now;
			rd_col_r <= a_s[MEM_COL_W-1:0];
			rd_ph_r <= 1'b0;
		end else if (rd_left_r != 4'h0) begin
			rd_ph_r <= ~rd_ph_r;
			if (!rd_ph_r) begin
				dq_r <= rword;
				dq_oe_n_r <= 1'b0;
				dqs_oe_n_r <= 1'b0;
			end else begin
				dqs_r <= ~dqs_r;
				rd_beat_r <= rd_beat_r + 4'h1;
				rd_left_r <= rd_left_r - 4'h1;
			end
		end else begin
			dq_oe_n_r <= 1'b1;
			dqs_oe_n_r <= 1'b1;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (rst) begin
			cmd_r <= CMD_NOP;
			stb_r <= 1'b0;
		end else begin
			stb_r <= go;
			if (go) begin
				cmd_r <= cmd;
			end
		end
	end

	assign BANK_OPEN_O = open_r;
	assign PWR_O = pwr_r;
	assign TERM_O = term_r;
	assign CMD_O = cmd_r;
	assign CMD_STB_O = stb_r;
	assign PIN.dq_d = dq_r;
	assign PIN.dq_d_oe_n = dq_oe_n_r;
	assign PIN.dqs_d = dqs_r;
	assign PIN.dqs_d_oe_n = dqs_oe_n_r;
endmodule : dci_dev

// >>> sim/dci_chk.sv
// concurrent checks on the memory pins between controller and device
`timescale 1ns/1ps
module dci_chk (
	input wire logic CLK_I, // clock
	input wire logic SYS_RST_I, // reset
	input wire logic ck, // memory clock
	input wire logic rst_n, // device reset
	input wire logic cke, // clock enable
	input wire logic cs_n, // select
	input wire logic ras_n, // row strobe
	input wire logic cas_n, // column strobe
	input wire logic we_n, // write enable
	input wire logic [2:0] ba, // bank
	input wire logic [12:0] a, // address
	input wire logic [1:0] dm, // mask
	input wire logic [15:0] dq_c, // write data
	input wire logic dq_c_oe_n, // data enable
	input wire logic dqs_c, // strobe
	input wire logic dqs_c_oe_n, // strobe enable
	input wire logic dq_d_oe_n // read enable
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (SYS_RST_I);
	ck_shape_a: assert property ($rose(ck) |=> ck ##1 !ck)
		else $error("memory clock high time wrong");
	cmd_stable_a: assert property ($rose(ck) |->
		$stable({cs_n, ras_n, cas_n, we_n, ba, a}))
		else $error("command pins moved at clock rise");
	cmd_len_a: assert property ($fell(cs_n) |-> !cs_n [*4] ##1
		(cs_n && ras_n && cas_n && we_n))
		else $error("command not one period then deselect");
	cke_acc_a: assert property ((!dq_c_oe_n || !dq_d_oe_n) |-> cke)
		else $error("clock enable low during access");
	beat_stable_a: assert property (
		($changed(dqs_c) && !dqs_c_oe_n) |-> $stable(dq_c) && $stable(dm))
		else $error("data or mask moved at strobe edge");
	mask_pair_a: assert property (!dq_c_oe_n |-> dm[0] == dm[1])
		else $error("lane masks differ");
	one_drv_a: assert property (!(!dq_c_oe_n && !dq_d_oe_n))
		else $error("both ends drive data");
	rst_pins_a: assert property ($fell(SYS_RST_I) |->
		!rst_n && !cke && cs_n && dq_c_oe_n)
		else $error("pins not at reset levels");
	cover property (!dq_c_oe_n);
	cover property (!dq_d_oe_n);
	cover property ($fell(cke));
endmodule : dci_chk

// >>> sim/dci_tb.sv
// self-checking bench joining the controller and device ends
`timescale 1ns/1ps
module dci_tb;
	import dci_pkg::*;
	`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
		n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); \
		end end
	`define WAITFOR(c) begin for (int k = 0; k < 80 && !(c); k++) \
		@(posedge clk); if (!(c)) begin n_errors++; conclude(); end end
	typedef struct {dci_cmd_t c; logic [2:0] b; logic [12:0] a;
		logic [15:0] wd; logic [7:0] mk; logic [7:0] op; logic [15:0] rd;
		logic st;} dci_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] av_addr = '0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wdata = '0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [7:0] bank_open;
	dci_pwr_t pwr;
	logic [1:0] term;
	dci_cmd_t cmd_o;
	logic cmd_stb;
	int n_errors = 0;
	int tests_run = 0;
	int n_stb = 0;
	logic [31:0] rdv;
	dci_row_t rows [16];
	dci_if pin ();
	dci_ctl i_dci_ctl (.CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(av_addr),
		.AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wdata),
		.AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait), .PIN(pin.ctl));
	dci_dev i_dci_dev (.CLK_I(clk), .SYS_RST_I(rst), .PIN(pin.dev),
		.BANK_OPEN_O(bank_open), .PWR_O(pwr), .TERM_O(term), .CMD_O(cmd_o),
		.CMD_STB_O(cmd_stb));
	dci_chk i_dci_chk (.CLK_I(clk), .SYS_RST_I(rst), .ck(pin.ck),
		.rst_n(pin.rst_n), .cke(pin.cke), .cs_n(pin.cs_n), .ras_n(pin.ras_n),
		.cas_n(pin.cas_n), .we_n(pin.we_n), .ba(pin.ba), .a(pin.a),
		.dm(pin.dm), .dq_c(pin.dq_c), .dq_c_oe_n(pin.dq_c_oe_n),
		.dqs_c(pin.dqs_c), .dqs_c_oe_n(pin.dqs_c_oe_n),
		.dq_d_oe_n(pin.dq_d_oe_n));
	always #10 clk = ~clk;
	always @(posedge clk) if (cmd_stb === 1'b1) n_stb++;
	task conclude;
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	task av(input logic w, input logic [4:0] ad, input logic [31:0] d);
		int k;
		k = 0;
		av_addr <= ad;
		av_wdata <= d;
		av_wr <= w;
		av_rd <= !w;
		do begin
			@(posedge clk);
			k++;
		end while (av_wait !== 1'b0 && k < 100);
		rdv = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge clk);
		if (k >= 100) begin
			n_errors++;
			conclude();
		end
	endtask : av
	task cmd(input dci_cmd_t c, input logic [2:0] b, input logic [12:0] a,
		input logic st, input logic [7:0] op);
		int s0;
		int k;
		s0 = n_stb;
		k = 0;
		av(1'b1, REG_ADDR, {16'h0, b, a});
		av(1'b1, REG_CMD, {28'h0, c});
		do begin
			av(1'b0, REG_STAT, 32'h0);
			k++;
		end while (rdv[0] !== 1'b0 && k < 50);
		if (rdv[0] !== 1'b0) begin
			n_errors++;
			conclude();
		end
		// an ignored command gets time to show a stray strobe
		if (st) `WAITFOR(n_stb != s0) else repeat (80) @(posedge clk);
		`CHK(n_stb, s0 + int'(st))
		if (st) `CHK(cmd_o, c)
		`CHK(bank_open, op)
	endtask : cmd
	initial begin
		rows = '{
			'{CMD_MRS, 3'h1, 13'h0004, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1},
			'{CMD_ACT, 3'h3, 13'h0001, 16'h0, 8'h0, 8'h08, 16'h0, 1'b1},
			'{CMD_WR, 3'h3, 13'h1002, 16'h1200, 8'h0, 8'h08, 16'h0, 1'b1},
			'{CMD_RD, 3'h3, 13'h1002, 16'h0, 8'h0, 8'h08, 16'h1200, 1'b1},
			'{CMD_WR, 3'h3, 13'h1002, 16'hab00, 8'h1, 8'h08, 16'h0, 1'b1},
			'{CMD_RD, 3'h3, 13'h1002, 16'h0, 8'h0, 8'h08, 16'h1200, 1'b1},
			'{CMD_WR, 3'h3, 13'h0000, 16'h5500, 8'h0, 8'h08, 16'h0, 1'b1},
			'{CMD_RD, 3'h3, 13'h1004, 16'h0, 8'h0, 8'h08, 16'hab02, 1'b1},
			'{CMD_RD, 3'h3, 13'h1400, 16'h0, 8'h0, 8'h00, 16'h5500, 1'b1},
			'{CMD_ACT, 3'h5, 13'h0001, 16'h0, 8'h0, 8'h20, 16'h0, 1'b1},
			'{CMD_PRE, 3'h5, 13'h0000, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1},
			'{CMD_ZQ, 3'h0, 13'h0000, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1},
			'{CMD_NOP, 3'h0, 13'h0000, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1},
			'{CMD_DES, 3'h0, 13'h0000, 16'h0, 8'h0, 8'h00, 16'h0, 1'b0},
			'{CMD_REF, 3'h0, 13'h0000, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1},
			'{CMD_MRS, 3'h2, 13'h0200, 16'h0, 8'h0, 8'h00, 16'h0, 1'b1}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		`CHK(pwr, PW_ON)
		`CHK(cmd_o, CMD_NOP)
		av(1'b0, REG_CTRL, 32'h0);
		`CHK(rdv[2:0], CTRL_RST)
		av(1'b0, 5'h1c, 32'h0);
		`CHK(rdv, 32'h0)
		`WAITFOR(pin.rst_n === 1'b1)
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].c == CMD_WR) begin
				av(1'b1, REG_WDATA, {16'h0, rows[i].wd});
				av(1'b1, REG_MASK, {24'h0, rows[i].mk});
			end
			cmd(rows[i].c, rows[i].b, rows[i].a, rows[i].st, rows[i].op);
			if (rows[i].c == CMD_RD) begin
				av(1'b0, REG_RDATA, 32'h0);
				`CHK(rdv[15:0], rows[i].rd)
			end
		end
		av(1'b1, REG_CTRL, 32'h7);
		`WAITFOR(term === 2'b11)
		`CHK(term, 2'b11)
		cmd(CMD_MRS, 3'h2, 13'h0, 1'b1, 8'h0);
		`CHK(term, 2'b11)
		cmd(CMD_MRS, 3'h1, 13'h0, 1'b1, 8'h0);
		`WAITFOR(term === 2'b00)
		`CHK(term, 2'b00)
		av(1'b1, REG_CTRL, 32'h5);
		for (int b = 0; b < 8; b++) begin
			cmd(CMD_ACT, 3'(b), 13'h1, 1'b1, 8'((9'h2 << b) - 9'h1));
		end
		av(1'b1, REG_CTRL, 32'h4);
		`WAITFOR(pwr === PW_APD)
		`CHK(pwr, PW_APD)
		av(1'b1, REG_CTRL, 32'h5);
		`WAITFOR(pwr === PW_ON)
		`CHK(pwr, PW_ON)
		cmd(CMD_PRE, 3'h0, 13'h400, 1'b1, 8'h0);
		av(1'b1, REG_CTRL, 32'h4);
		`WAITFOR(pwr === PW_PPD)
		`CHK(pwr, PW_PPD)
		cmd(CMD_ACT, 3'h0, 13'h1, 1'b0, 8'h0);
		av(1'b1, REG_CTRL, 32'h5);
		`WAITFOR(pwr === PW_ON)
		cmd(CMD_MRS, 3'h1, 13'h4, 1'b1, 8'h0);
		av(1'b1, REG_CTRL, 32'h7);
		`WAITFOR(term === 2'b11)
		// start the refresh so cke falls inside its own clock period
		`WAITFOR(pin.ck === 1'b0)
		`WAITFOR(pin.ck === 1'b1)
		av(1'b1, REG_CMD, {28'h0, CMD_REF});
		av(1'b1, REG_CTRL, 32'h6);
		`WAITFOR(pwr === PW_SR)
		`CHK(pwr, PW_SR)
		@(posedge clk);
		`CHK(term, 2'b00)
		cmd(CMD_ACT, 3'h0, 13'h1, 1'b0, 8'h0);
		av(1'b1, REG_CTRL, 32'h5);
		`WAITFOR(pwr === PW_ON)
		`CHK(pwr, PW_ON)
		cmd(CMD_ACT, 3'h3, 13'h1, 1'b1, 8'h08);
		av(1'b1, REG_CTRL, 32'h1);
		`WAITFOR(pin.rst_n === 1'b0)
		repeat (4) @(posedge clk);
		av(1'b1, REG_CTRL, 32'h5);
		`WAITFOR(pin.rst_n === 1'b1)
		repeat (4) @(posedge clk);
		`CHK(bank_open, 8'h0)
		cmd(CMD_ACT, 3'h3, 13'h1, 1'b1, 8'h08);
		cmd(CMD_RD, 3'h3, 13'h1002, 1'b1, 8'h08);
		av(1'b0, REG_RDATA, 32'h0);
		`CHK(rdv[15:0], 16'h0)
		conclude();
	end
endmodule : dci_tb
